// >>> bpp_parser.sv
// Slot plan table parser with APB register file
`timescale 1ns/100ps
`default_nettype none
module bpp_parser (
	// Clock, reset, enable
	input  wire logic                mclk_i,
	input  wire logic                sys_rst_i,
	input  wire logic                ce_i,
	// APB slave
	input  wire logic                psel_i,
	input  wire logic                penable_i,
	input  wire logic                pwrite_i,
	input  wire logic [7:0]          paddr_i,
	input  wire logic [31:0]         pwdata_i,
	output logic      [31:0]         prdata_o,
	output logic                     pready_o,
	output logic                     pslverr_o,
	// Table byte stream
	input  wire logic                tbl_start_i,
	input  wire logic                byte_vld_i,
	input  wire logic [7:0]          byte_i,
	// Grant output
	output logic                     grant_vld_o,
	output bpp_pkg::bpp_grant_s      grant_o,
	output logic                     tbl_done_o
);
	logic [31:0]             ctrl_r;
	logic [31:0]             cfg_r;
	logic [31:0]             limit_r;
	logic [31:0]             prdata_r;
	logic                    pready_r;
	logic                    pslverr_r;
	bpp_pkg::bpp_state_e     state_r;
	bpp_pkg::bpp_state_e     entry_st;
	logic [7:0]              cnt_r;
	logic [7:0]              need_r;
	logic [7:0]              entry_need;
	logic [7:0]              tag_r;
	logic [7:0]              seq_r;
	logic [7:0]              ctx_r;
	logic [7:0]              sfc_r;
	logic [7:0]              fmt_r;
	logic [7:0]              frm_left_r;
	logic [7:0]              fidx_r;
	logic [7:0]              txt_r;
	logic [15:0]             asg_left_r;
	logic [15:0]             slot_r;
	logic [15:0]             grant_cnt_r;
	logic [15:0]             drop_cnt_r;
	logic                    accepted_r;
	logic                    fmt_bad_r;
	logic                    grant_vld_r;
	logic                    done_r;
	bpp_pkg::bpp_grant_s     grant_r;
	bpp_pkg::bpp_grant_s     grant_nxt;
	bpp_pkg::bpp_bct_s       lut_ent;
	logic [47:0]             fld_val;
	logic [47:0]             fld_q;
	logic [47:0]             id_val;
	logic [7:0]              slen;
	logic [7:0]              h_fmt;
	logic [7:0]              h_ctx;
	logic                    start;
	logic                    in_parse;
	logic                    fld_done;
	logic                    hdr_done;
	logic                    frm_done;
	logic                    txt_done;
	logic                    gid_done;
	logic                    ent_done;
	logic                    last_asg;
	logic                    last_frm;
	logic                    fmt_ok;
	logic                    ctx_ok;
	logic                    hdr_ok;
	logic                    use_lut;
	logic                    lut_hit;
	logic                    miss;
	logic                    apb_setup;
	logic                    apb_wr;

	// APB slave: zero wait states, answer prepared in the setup cycle
	assign apb_setup = psel_i && !penable_i;
	assign apb_wr    = psel_i && penable_i && pready_r && pwrite_i;

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end
		else if (ce_i)
		begin
			pready_r  <= apb_setup;
			pslverr_r <= 1'b0;
			if (apb_setup)
			begin
				case (paddr_i)
					bpp_pkg::REG_CTRL:  prdata_r <= ctrl_r;
					bpp_pkg::REG_CFG:   prdata_r <= cfg_r;
					bpp_pkg::REG_LIMIT: prdata_r <= limit_r;
					bpp_pkg::REG_BCT:   prdata_r <= 32'h0;
					bpp_pkg::REG_HDR:
						prdata_r <= {sfc_r, ctx_r, seq_r, tag_r};
					bpp_pkg::REG_STAT:
						prdata_r <= {grant_cnt_r, 5'h0, fmt_bad_r,
							accepted_r, state_r != bpp_pkg::BPP_ST_IDLE &&
							state_r != bpp_pkg::BPP_ST_SKIP, fmt_r};
					bpp_pkg::REG_DROP:  prdata_r <= {16'h0, drop_cnt_r};
					default:
					begin
						prdata_r  <= 32'h0;
						pslverr_r <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_r  <= bpp_pkg::CTRL_RST;
			cfg_r   <= bpp_pkg::CFG_RST;
			limit_r <= bpp_pkg::LIMIT_RST;
		end
		else if (ce_i && apb_wr)
		begin
			if (paddr_i == bpp_pkg::REG_CTRL)
				ctrl_r <= pwdata_i;
			if (paddr_i == bpp_pkg::REG_CFG)
				cfg_r <= pwdata_i;
			if (paddr_i == bpp_pkg::REG_LIMIT)
				limit_r <= pwdata_i;
		end
	end

	bpp_field_acc u_acc (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.shift_i   (byte_vld_i),
		.byte_i    (byte_i),
		.val_o     (fld_val)
	);

	bpp_bct_lut u_lut (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.ce_i      (ce_i),
		.wr_i      (apb_wr && paddr_i == bpp_pkg::REG_BCT),
		.wr_idx_i  (pwdata_i[bpp_pkg::BCT_IDX_LSB +: 4]),
		.wr_ent_i  ({pwdata_i[bpp_pkg::BCT_VLD_BIT], pwdata_i[23:0]}),
		.rd_type_i (txt_r),
		.rd_ent_o  (lut_ent),
		.rd_hit_o  (lut_hit)
	);

	// Field sequencing
	assign start    = ce_i && byte_vld_i && tbl_start_i &&
		ctrl_r[bpp_pkg::CTRL_EN];
	assign in_parse = state_r != bpp_pkg::BPP_ST_IDLE &&
		state_r != bpp_pkg::BPP_ST_SKIP;
	assign fld_done = ce_i && byte_vld_i && !tbl_start_i && in_parse &&
		cnt_r == need_r - 8'h01;
	assign hdr_done = fld_done && state_r == bpp_pkg::BPP_ST_HDR;
	assign frm_done = fld_done && state_r == bpp_pkg::BPP_ST_FRM;
	assign txt_done = fld_done && state_r == bpp_pkg::BPP_ST_TXT;
	assign gid_done = fld_done && state_r == bpp_pkg::BPP_ST_GID;
	assign ent_done = gid_done ||
		(fld_done && state_r == bpp_pkg::BPP_ST_USR);
	assign last_asg = asg_left_r == 16'h0;
	assign last_frm = frm_left_r == 8'h00;

	// Header acceptance, decided on the header's last byte
	assign h_fmt  = fld_val[15:8];
	assign h_ctx  = fld_val[31:24];
	assign fmt_ok = bpp_pkg::bpp_id_len(h_fmt) != 8'h00 ||
		(h_fmt >= bpp_pkg::FMT_USER_MIN && ctrl_r[bpp_pkg::CTRL_FMTU] &&
		cfg_r[bpp_pkg::CFG_ULEN_LSB +: 8] != 8'h00);

	always_comb
	begin
		if (h_ctx == bpp_pkg::CTX_ALL)
			ctx_ok = !ctrl_r[bpp_pkg::CTRL_LOGON];
		else if (h_ctx == bpp_pkg::CTX_STAR)
			ctx_ok = ctrl_r[bpp_pkg::CTRL_CTX1];
		else if (h_ctx == bpp_pkg::CTX_LOGON)
			ctx_ok = ctrl_r[bpp_pkg::CTRL_CTX2];
		else if (h_ctx >= bpp_pkg::CTX_USER_MIN)
			ctx_ok = ctrl_r[bpp_pkg::CTRL_CTXU];
		else
			ctx_ok = 1'b0;
	end

	assign hdr_ok = fmt_ok && ctx_ok &&
		fld_val[47:40] == cfg_r[bpp_pkg::CFG_TAG_LSB +: 8];

	// What the next assignment entry looks like
	always_comb
	begin
		if (fmt_r >= bpp_pkg::FMT_USER_MIN)
		begin
			entry_st   = bpp_pkg::BPP_ST_USR;
			entry_need = cfg_r[bpp_pkg::CFG_ULEN_LSB +: 8];
		end
		else if (bpp_pkg::bpp_has_txt(fmt_r))
		begin
			entry_st   = bpp_pkg::BPP_ST_TXT;
			entry_need = bpp_pkg::TXT_LEN;
		end
		else
		begin
			entry_st   = bpp_pkg::BPP_ST_GID;
			entry_need = bpp_pkg::bpp_id_len(fmt_r);
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			state_r <= bpp_pkg::BPP_ST_IDLE;
			need_r  <= 8'h00;
			cnt_r   <= 8'h00;
		end
		else if (ce_i)
		begin
			if (start)
			begin
				state_r <= bpp_pkg::BPP_ST_HDR;
				need_r  <= bpp_pkg::HDR_LEN;
				cnt_r   <= 8'h01;
			end
			else if (in_parse && byte_vld_i)
			begin
				cnt_r <= fld_done ? 8'h00 : cnt_r + 8'h01;
				if (hdr_done && !hdr_ok)
					state_r <= bpp_pkg::BPP_ST_SKIP;
				else if (hdr_done)
				begin
					state_r <= bpp_pkg::BPP_ST_FRM;
					need_r  <= bpp_pkg::FRM_LEN;
				end
				else if (txt_done)
				begin
					state_r <= bpp_pkg::BPP_ST_GID;
					need_r  <= bpp_pkg::bpp_id_len(fmt_r);
				end
				else if ((ent_done && last_asg && !last_frm))
				begin
					state_r <= bpp_pkg::BPP_ST_FRM;
					need_r  <= bpp_pkg::FRM_LEN;
				end
				else if (ent_done && last_asg)
					state_r <= bpp_pkg::BPP_ST_IDLE;
				else if (frm_done || ent_done)
				begin
					state_r <= entry_st;
					need_r  <= entry_need;
				end
			end
		end
	end

	// Header and frame fields
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			{tag_r, seq_r, ctx_r, sfc_r, fmt_r, frm_left_r} <= 48'h0;
			fidx_r     <= 8'h00;
			asg_left_r <= 16'h0;
			txt_r      <= 8'h00;
		end
		else if (ce_i)
		begin
			if (hdr_done)
				{tag_r, seq_r, ctx_r, sfc_r, fmt_r, frm_left_r} <=
					fld_val;
			else if (ent_done && last_asg && !last_frm)
				frm_left_r <= frm_left_r - 8'h01;
			if (frm_done)
			begin
				fidx_r     <= fld_val[39:32];
				asg_left_r <= fld_val[15:0];
			end
			else if (ent_done && !last_asg)
				asg_left_r <= asg_left_r - 16'h1;
			if (txt_done)
				txt_r <= fld_val[7:0];
			else if (frm_done)
				txt_r <= 8'h00;
		end
	end

	// Slot position walks forward entry by entry
	assign use_lut = bpp_pkg::bpp_has_txt(fmt_r) && txt_r != 8'h00;
	assign miss    = use_lut && !lut_hit;
	assign slen    = (use_lut && lut_hit) ? lut_ent.burst_time_unit :
		cfg_r[bpp_pkg::CFG_DLEN_LSB +: 8];

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			slot_r <= 16'h0;
		else if (ce_i && frm_done)
			slot_r <= fld_val[31:16];
		else if (ce_i && ent_done)
			slot_r <= slot_r + {8'h00, slen};
	end

	always_comb
	begin
		case (bpp_pkg::bpp_id_len(fmt_r))
			8'h01:   id_val = {40'h0, fld_val[7:0]};
			8'h02:   id_val = {32'h0, fld_val[15:0]};
			8'h03:   id_val = {24'h0, fld_val[23:0]};
			default: id_val = fld_val;
		endcase
	end

	always_comb
	begin
		grant_nxt            = '0;
		grant_nxt.ctx        = ctx_r;
		grant_nxt.sf_count   = sfc_r;
		grant_nxt.frame_idx  = fidx_r;
		grant_nxt.slot_start = slot_r;
		grant_nxt.slot_len   = slen;
		grant_nxt.tx_type    = txt_r;
		grant_nxt.modcod     = use_lut ? lut_ent.modcod : 8'h00;
		grant_nxt.ptype      = use_lut ? lut_ent.ptype : 8'h00;
		grant_nxt.id         = id_val;
		if (id_val == 48'h0)
			grant_nxt.cls = bpp_pkg::BPP_CLS_VOID;
		else if (id_val <= {16'h0, limit_r})
			grant_nxt.cls = bpp_pkg::BPP_CLS_DED;
		else
			grant_nxt.cls = bpp_pkg::BPP_CLS_RAND;
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			grant_r     <= '0;
			grant_vld_r <= 1'b0;
			done_r      <= 1'b0;
		end
		else if (ce_i)
		begin
			grant_vld_r <= gid_done && !miss;
			done_r      <= ent_done && last_asg && last_frm;
			if (gid_done && !miss)
				grant_r <= grant_nxt;
		end
	end

	// Status: counters wrap, the bad-format flag is cleared by writing 1
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			grant_cnt_r <= 16'h0;
			drop_cnt_r  <= 16'h0;
			accepted_r  <= 1'b0;
			fmt_bad_r   <= 1'b0;
		end
		else if (ce_i)
		begin
			if (gid_done && !miss)
				grant_cnt_r <= grant_cnt_r + 16'h1;
			if (gid_done && miss)
				drop_cnt_r <= drop_cnt_r + 16'h1;
			if (hdr_done)
				accepted_r <= hdr_ok;
			// Set wins over a clear in the same cycle
			if (hdr_done && !fmt_ok)
				fmt_bad_r <= 1'b1;
			else if (apb_wr && paddr_i == bpp_pkg::REG_STAT &&
				pwdata_i[bpp_pkg::STAT_FMT_BAD])
				fmt_bad_r <= 1'b0;
		end
	end

	// Copy of the last field, only for the checks below
	always_ff @(posedge mclk_i)
		if (ce_i)
			fld_q <= fld_val;

	assign prdata_o    = prdata_r;
	assign pready_o    = pready_r;
	assign pslverr_o   = pslverr_r;
	assign grant_vld_o = grant_vld_r;
	assign grant_o     = grant_r;
	assign tbl_done_o  = done_r;

	a_hdr_capture: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		hdr_done |=> tag_r == fld_q[47:40] && fmt_r == fld_q[15:8] &&
			sfc_r == fld_q[23:16])
		else $error("header fields not captured in order");
	a_frame_loop: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		hdr_done && hdr_ok |=> state_r == bpp_pkg::BPP_ST_FRM &&
			frm_left_r == fld_q[7:0])
		else $error("frame loop count not loaded");
	a_asg_loop: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		frm_done |=> asg_left_r == fld_q[15:0] && fidx_r == fld_q[39:32])
		else $error("frame entry fields wrong");
	a_id_width: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		state_r == bpp_pkg::BPP_ST_GID |->
			need_r == bpp_pkg::bpp_id_len(fmt_r) && need_r != 8'h00)
		else $error("identifier width does not follow format");
	a_reserved_fmt: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		hdr_done && !fmt_ok |=> state_r == bpp_pkg::BPP_ST_SKIP && fmt_bad_r)
		else $error("reserved format was parsed");
	a_slot_offset: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		frm_done |=> slot_r == fld_q[31:16])
		else $error("slot offset not applied");
	a_next_slot: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		ent_done |=> slot_r == 16'($past(slot_r) + {8'h00, $past(slen)}))
		else $error("slot position not advanced by length");
	a_logon_skip: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		hdr_done && h_ctx == bpp_pkg::CTX_ALL &&
			ctrl_r[bpp_pkg::CTRL_LOGON] |=> state_r == bpp_pkg::BPP_ST_SKIP)
		else $error("context zero parsed while logging on");
	a_grant_class: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		grant_vld_o |-> (grant_o.id == 48'h0) ==
			(grant_o.cls == bpp_pkg::BPP_CLS_VOID))
		else $error("void identifier misclassified");
	a_drop_miss: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		gid_done && miss |=> !grant_vld_o &&
			drop_cnt_r == 16'($past(drop_cnt_r) + 16'h1))
		else $error("unknown transmit type was granted");
	a_group_tag: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		hdr_done && fld_val[47:40] != cfg_r[7:0] |=>
			state_r == bpp_pkg::BPP_ST_SKIP)
		else $error("table for another group parsed");
endmodule : bpp_parser
`default_nettype wire

// >>> bpp_pkg.sv
// Package: constants, types and helpers for the slot plan table parser
package bpp_pkg;
	// APB register byte addresses
	localparam logic [7:0] REG_CTRL  = 8'h00;
	localparam logic [7:0] REG_CFG   = 8'h04;
	localparam logic [7:0] REG_LIMIT = 8'h08;
	localparam logic [7:0] REG_BCT   = 8'h0c;
	localparam logic [7:0] REG_HDR   = 8'h10;
	localparam logic [7:0] REG_STAT  = 8'h14;
	localparam logic [7:0] REG_DROP  = 8'h18;
	// Field positions
	localparam int CTRL_EN      = 0;
	localparam int CTRL_LOGON   = 1;
	localparam int CTRL_CTX1    = 2;
	localparam int CTRL_CTX2    = 3;
	localparam int CTRL_CTXU    = 4;
	localparam int CTRL_FMTU    = 5;
	localparam int CFG_TAG_LSB  = 0;
	localparam int CFG_DLEN_LSB = 8;
	localparam int CFG_ULEN_LSB = 16;
	localparam int BCT_VLD_BIT  = 31;
	localparam int BCT_IDX_LSB  = 24;
	localparam int STAT_FMT_BAD = 10;
	// Values after reset
	localparam logic [31:0] CTRL_RST  = 32'h0000000d;
	localparam logic [31:0] CFG_RST   = 32'h00010100;
	localparam logic [31:0] LIMIT_RST = 32'h00000100;
	// Field lengths in bytes
	localparam logic [7:0] HDR_LEN = 8'h06;
	localparam logic [7:0] FRM_LEN = 8'h05;
	localparam logic [7:0] TXT_LEN = 8'h01;
	// Layout formats and contexts
	localparam logic [7:0] FMT_ID48     = 8'h00;
	localparam logic [7:0] FMT_ID8      = 8'h01;
	localparam logic [7:0] FMT_ID16     = 8'h02;
	localparam logic [7:0] FMT_ID24     = 8'h03;
	localparam logic [7:0] FMT_TX8      = 8'h0a;
	localparam logic [7:0] FMT_TX16     = 8'h0b;
	localparam logic [7:0] FMT_TX24     = 8'h0c;
	localparam logic [7:0] FMT_USER_MIN = 8'h80;
	localparam logic [7:0] CTX_ALL      = 8'h00;
	localparam logic [7:0] CTX_STAR     = 8'h01;
	localparam logic [7:0] CTX_LOGON    = 8'h02;
	localparam logic [7:0] CTX_USER_MIN = 8'h80;
	// Burst configuration lookup
	localparam int LUT_DEPTH = 16;
	localparam int LUT_IDX_W = 4;

	typedef enum logic [6:0] {
		BPP_ST_IDLE = 7'h01,
		BPP_ST_HDR  = 7'h02,
		BPP_ST_FRM  = 7'h04,
		BPP_ST_TXT  = 7'h08,
		BPP_ST_GID  = 7'h10,
		BPP_ST_USR  = 7'h20,
		BPP_ST_SKIP = 7'h40
	} bpp_state_e;

	typedef enum logic [1:0] {
		BPP_CLS_VOID = 2'h0,
		BPP_CLS_DED  = 2'h1,
		BPP_CLS_RAND = 2'h2
	} bpp_cls_e;

	typedef struct packed {
		logic       vld;
		logic [7:0] ptype;
		logic [7:0] modcod;
		logic [7:0] burst_time_unit;
	} bpp_bct_s;

	typedef struct packed {
		logic [7:0]  ctx;
		logic [7:0]  sf_count;
		logic [7:0]  frame_idx;
		logic [15:0] slot_start;
		logic [7:0]  slot_len;
		logic [7:0]  tx_type;
		logic [7:0]  modcod;
		logic [7:0]  ptype;
		logic [47:0] id;
		bpp_cls_e    cls;
	} bpp_grant_s;

	// Identifier length in bytes, zero for a reserved format
	function automatic logic [7:0] bpp_id_len(input logic [7:0] fmt);
		case (fmt)
			FMT_ID48:          bpp_id_len = 8'h06;
			FMT_ID8, FMT_TX8:  bpp_id_len = 8'h01;
			FMT_ID16, FMT_TX16: bpp_id_len = 8'h02;
			FMT_ID24, FMT_TX24: bpp_id_len = 8'h03;
			default:           bpp_id_len = 8'h00;
		endcase
	endfunction : bpp_id_len

	function automatic logic bpp_has_txt(input logic [7:0] fmt);
		bpp_has_txt = (fmt == FMT_TX8) || (fmt == FMT_TX16) ||
			(fmt == FMT_TX24);
	endfunction : bpp_has_txt
endpackage : bpp_pkg

// >>> bpp_field_acc.sv
// Byte shifter that assembles multi-byte table fields
`timescale 1ns/100ps
`default_nettype none
module bpp_field_acc (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	// Byte stream
	input  wire logic        shift_i,
	input  wire logic [7:0]  byte_i,
	// Field value ending with the current byte
	output logic      [47:0] val_o
);
	logic [39:0] acc_r;

	// Fields other than user-format entries never exceed six bytes, so stale upper bytes fall off the
	// top and no clear between fields is needed
	always_ff @(posedge mclk_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			acc_r <= 40'h0;
		else if (ce_i && shift_i)
			acc_r <= {acc_r[31:0], byte_i};
	end

	assign val_o = {acc_r, byte_i};
endmodule : bpp_field_acc
`default_nettype wire

// >>> bpp_bct_lut.sv
// Burst configuration lookup held in flip-flops
`timescale 1ns/100ps
`default_nettype none
module bpp_bct_lut (
	// Clock and reset
	input  wire logic                 mclk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 ce_i,
	// Software write port
	input  wire logic                 wr_i,
	input  wire logic [3:0]           wr_idx_i,
	input  wire bpp_pkg::bpp_bct_s    wr_ent_i,
	// Lookup port
	input  wire logic [7:0]           rd_type_i,
	output bpp_pkg::bpp_bct_s         rd_ent_o,
	output logic                      rd_hit_o
);
	bpp_pkg::bpp_bct_s ent_q [bpp_pkg::LUT_DEPTH];

	genvar g;
	generate
		for (g = 0; g < bpp_pkg::LUT_DEPTH; g++)
		begin : g_ent
			bpp_pkg::bpp_bct_s ent_r;
			always_ff @(posedge mclk_i or posedge sys_rst_i)
			begin
				if (sys_rst_i)
					ent_r <= '0;
				else if (ce_i && wr_i &&
					wr_idx_i == 4'(g))
					ent_r <= wr_ent_i;
			end
			assign ent_q[g] = ent_r;
		end
	endgenerate

	assign rd_ent_o = ent_q[rd_type_i[bpp_pkg::LUT_IDX_W-1:0]];
	// Types beyond the table, unset entries or a zero length are misses
	assign rd_hit_o = (rd_type_i < 8'(bpp_pkg::LUT_DEPTH)) &&
		rd_ent_o.vld && (rd_ent_o.burst_time_unit != 8'h00);
endmodule : bpp_bct_lut
`default_nettype wire

// >>> bpp_ncc_model.sv
// Control centre model that plays slot plan tables onto the byte stream
`timescale 1ns/100ps
`default_nettype none
module bpp_ncc_model (
	// Clock
	input  wire logic       mclk_i,
	// Table stream
	output logic            tbl_start_o,
	output logic            byte_vld_o,
	output logic      [7:0] byte_o
);
	initial
	begin
		tbl_start_o = 1'b0;
		byte_vld_o  = 1'b0;
		byte_o      = 8'h00;
	end

	// Idle data shows the inverse of the last byte so stale values never match
	task automatic send(input logic [7:0] b[$], input bit gap);
		foreach (b[i])
		begin
			@(posedge mclk_i);
			tbl_start_o <= (i == 0);
			byte_vld_o  <= 1'b1;
			byte_o      <= b[i];
			if (gap)
			begin
				@(posedge mclk_i);
				tbl_start_o <= 1'b0;
				byte_vld_o  <= 1'b0;
				byte_o      <= ~b[i];
			end
		end
		@(posedge mclk_i);
		tbl_start_o <= 1'b0;
		byte_vld_o  <= 1'b0;
		byte_o      <= ~b[b.size()-1];
	endtask : send
endmodule : bpp_ncc_model
`default_nettype wire

// >>> burst_time_plan_parser_tb_top.sv
// Self-checking testbench for the slot plan table parser
`timescale 1ns/100ps
`default_nettype none
module burst_time_plan_parser_tb_top;
	logic                mclk_i, sys_rst_i, psel, penable, pwrite;
	logic                pready, pslverr, er, tst, bvld, gvld, done;
	logic         [7:0]  paddr, bs;
	logic         [31:0] pwdata, prdata, rd;
	logic         [47:0] id;
	logic         [7:0]  q[$];
	logic         [7:0]  fmts[7] = '{0, 1, 2, 3, 8'h0a, 8'h0b, 8'h0c};
	int                  lens[7] = '{6, 1, 2, 3, 1, 2, 3};
	bpp_pkg::bpp_grant_s grant, gq[$];
	logic                dq[$];
	int                  failures, n_tests, cyc;

	bpp_parser u_bpp_parser (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.ce_i(1'b1), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .tbl_start_i(tst),
		.byte_vld_i(bvld), .byte_i(bs), .grant_vld_o(gvld), .grant_o(grant),
		.tbl_done_o(done));
	bpp_ncc_model u_bpp_ncc_model (.mclk_i(mclk_i), .tbl_start_o(tst),
		.byte_vld_o(bvld), .byte_o(bs));

	initial
	begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	// Sampled mid-cycle so the one-cycle pulse is seen once
	always @(negedge mclk_i)
		if (gvld === 1'b1)
		begin
			gq.push_back(grant);
			dq.push_back(done);
		end

	always @(posedge mclk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			failures++;
			test_done();
		end
	end

	task automatic test_done();
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic chk32(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			failures++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk32

	task automatic chk_grant(input bpp_pkg::bpp_grant_s e, input logic de);
		bpp_pkg::bpp_grant_s g = 'x;
		logic                d = 1'bx;
		n_tests++;
		if (gq.size() != 0)
		begin
			g = gq.pop_front();
			d = dq.pop_front();
		end
		if (g !== e || d !== de)
		begin
			failures++;
			$display("BAD grant exp %h/%b got %h/%b", e, de, g, d);
		end
	endtask : chk_grant

	// Dedicated range ends at the limit written below
	function automatic bpp_pkg::bpp_grant_s eg(input logic [7:0] c, s, f,
		input logic [15:0] st, input logic [7:0] ln, tx, mc, pt,
		input logic [47:0] i);
		eg = {c, s, f, st, ln, tx, mc, pt, i, 2'h0};
		eg.cls = (i == 0) ? bpp_pkg::BPP_CLS_VOID : (i <= 48'h10) ?
			bpp_pkg::BPP_CLS_DED : bpp_pkg::BPP_CLS_RAND;
	endfunction : eg

	task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		// Access ends at the edge that samples pready high; hangs end by timeout
		do
			@(posedge mclk_i);
		while (pready !== 1'b1);
		rd      = prdata;
		er      = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : ap

	task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] e);
		ap(1'b0, a, 32'h0);
		chk32(nm, e, rd);
	endtask : rc

	task automatic pb(input logic [7:0] b);
		q.push_back(b);
	endtask : pb

	task automatic hdr(input logic [7:0] t, s, c, sf, f, fl);
		q = '{t, s, c, sf, f, fl};
	endtask : hdr

	task automatic frm(input logic [7:0] i, input logic [15:0] o, n);
		q = {q, i, o[15:8], o[7:0], n[15:8], n[7:0]};
	endtask : frm

	task automatic run(input bit gap);
		u_bpp_ncc_model.send(q, gap);
		repeat (4) @(posedge mclk_i);
	endtask : run

	task automatic one(input logic [7:0] t, c, f);
		hdr(t, 8'h04, c, 8'h00, f, 8'h00);
		frm(8'h00, 16'h0000, 16'h0000);
		pb(8'h22);
		run(1'b1);
	endtask : one

	initial
	begin
		{failures, n_tests} = '0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		sys_rst_i = 1'b1;
		repeat (12) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		rc("ctrl", bpp_pkg::REG_CTRL, bpp_pkg::CTRL_RST);
		rc("cfg", bpp_pkg::REG_CFG, bpp_pkg::CFG_RST);
		rc("limit", bpp_pkg::REG_LIMIT, bpp_pkg::LIMIT_RST);
		rc("unmapped", 8'h1c, 32'h0);
		chk32("slverr", 32'h1, {31'h0, er});
		ap(1'b1, bpp_pkg::REG_CFG, 32'h00020205);
		ap(1'b1, bpp_pkg::REG_LIMIT, 32'h10);
		ap(1'b1, bpp_pkg::REG_BCT, 32'h83332204);
		// Two frames, offset skip, gapped bytes
		hdr(8'h05, 8'h01, 8'h00, 8'hff, 8'h01, 8'h01);
		frm(8'h00, 16'h0005, 16'h0002);
		q = {q, 8'h00, 8'h10, 8'h11};
		frm(8'h01, 16'hfffe, 16'h0000);
		pb(8'hff);
		run(1'b1);
		rc("hdr", bpp_pkg::REG_HDR, 32'hff000105);
		chk_grant(eg(0, 8'hff, 0, 5, 2, 0, 0, 0, 0), 0);
		chk_grant(eg(0, 8'hff, 0, 7, 2, 0, 0, 0, 8'h10), 0);
		chk_grant(eg(0, 8'hff, 0, 9, 2, 0, 0, 0, 8'h11), 0);
		chk_grant(eg(0, 8'hff, 1, 16'hfffe, 2, 0, 0, 0, 8'hff), 1);
		// Typed entries, back to back, unknown type in the middle
		hdr(8'h05, 8'h02, 8'h01, 8'h00, 8'h0b, 8'h00);
		frm(8'h02, 16'h0000, 16'h0002);
		q = {q, 8'h03, 8'h00, 8'h01, 8'h07, 8'h00, 8'h11};
		q = {q, 8'h00, 8'h00, 8'h10};
		run(1'b0);
		chk_grant(eg(1, 0, 2, 0, 4, 3, 8'h22, 8'h33, 1), 0);
		chk_grant(eg(1, 0, 2, 6, 2, 0, 0, 0, 8'h10), 1);
		rc("drop", bpp_pkg::REG_DROP, 32'h1);
		for (int k = 0; k < 7; k++)
		begin
			hdr(8'h05, 8'h03, 8'h02, k[7:0], fmts[k], 8'h00);
			frm(8'h00, 16'h0000, 16'h0000);
			if (fmts[k] >= 8'h0a)
				pb(8'h00);
			id = '0;
			for (int j = 0; j < lens[k]; j++)
			begin
				pb(8'h0f + j[7:0]);
				id = {id[39:0], 8'h0f + j[7:0]};
			end
			run(1'b0);
			chk_grant(eg(2, k[7:0], 0, 0, 2, 0, 0, 0, id), 1);
		end
		// Foreign tag, reserved format, reserved context
		one(8'h06, 8'h00, 8'h01);
		one(8'h05, 8'h00, 8'h05);
		one(8'h05, 8'h03, 8'h01);
		ap(1'b1, bpp_pkg::REG_CTRL, 32'h0000000f);
		one(8'h05, 8'h00, 8'h01);
		one(8'h05, 8'h01, 8'h01);
		chk_grant(eg(1, 0, 0, 0, 2, 0, 0, 0, 8'h22), 1);
		chk32("extra", 32'h0, gq.size());
		ap(1'b0, bpp_pkg::REG_STAT, 32'h0);
		chk32("fmt_bad", 32'h1, {31'h0, rd[10]});
		// User format: two entries, no grant; flag cleared by writing one
		ap(1'b1, bpp_pkg::REG_CTRL, 32'h0000002f);
		ap(1'b1, bpp_pkg::REG_STAT, 32'h00000400);
		hdr(8'h05, 8'h05, 8'h01, 8'h00, 8'h80, 8'h00);
		frm(8'h00, 16'h0000, 16'h0001);
		q = {q, 8'h01, 8'h02, 8'h03, 8'h04};
		run(1'b0);
		chk32("user", 32'h0, gq.size());
		rc("stat", bpp_pkg::REG_STAT, 32'h000e0280);
		test_done();
	end
endmodule : burst_time_plan_parser_tb_top
`default_nettype wire
